// *** wwd_top.sv ***
// windowed watchdog: timeout counter, mode select, service check and error response
`include "wwd_defs.svh"
`default_nettype none
module wwd_top #(
  parameter int               COUNT_W = `WWD_COUNT_W,
  parameter int               KEY_W   = `WWD_KEY_W,
  parameter logic [KEY_W-1:0] KEY_VAL = `WWD_KEY_VAL
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               service_key_wr,
  input  wire logic [KEY_W-1:0]   service_key,
  input  wire logic               windowed_mode,
  input  wire logic               irq_response_select,
  input  wire logic [COUNT_W-1:0] timeout_limit,
  input  wire logic [COUNT_W-1:0] window_lower,
  input  wire logic [COUNT_W-1:0] window_upper,
  output logic                    warm_rst_req,
  output logic                    cpu_irq,
  output logic                    windowed_active,
  output logic [COUNT_W-1:0]      wd_count
);

  // ****************************************
  // parameter checks
  // ****************************************
  if (COUNT_W < 2 || COUNT_W > `WWD_COUNT_W) begin : g_bad_count_w
    $error("wwd_top: COUNT_W must lie between 2 and the header width");
  end
  if (KEY_W < 1) begin : g_bad_key_w
    $error("wwd_top: KEY_W must be at least 1");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic               windowed;
    logic               rst_req;
    logic               irq;
  } wwd_state_t;

  wwd_state_t         st_q;
  wwd_state_t         st_d;
  wwd_pkg::wwd_svc_t  svc;
  logic [COUNT_W-1:0] limit;
  logic               mode_chg;
  logic               expired;
  logic               fail;

  // one mode only: the limit comes from either the timeout or the upper bound
  assign limit    = st_q.windowed ? window_upper : timeout_limit;   // see R1 see R5
  assign mode_chg = windowed_mode != st_q.windowed;

  wwd_key_check #(
    .COUNT_W (COUNT_W),
    .KEY_W   (KEY_W),
    .KEY_VAL (KEY_VAL)
  ) u_key_check (
    .key      (service_key),
    .key_wr   (service_key_wr),
    .windowed (st_q.windowed),
    .count    (st_q.count),
    .lower    (window_lower),
    .limit    (limit),
    .svc      (svc)
  );

  // ****************************************
  // failure detection
  // ****************************************
  // a key written in the last allowed cycle still counts, so expiry yields to it
  assign expired = (st_q.count >= limit) && (svc != wwd_pkg::WWD_SVC_OK);  // see R2 see R6
  // a mode switch starts a fresh period and forgives the old one
  assign fail    = !mode_chg && (expired || svc == wwd_pkg::WWD_SVC_BAD);   // see R2 see R6

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_d          = st_q;
    st_d.rst_req  = 1'b0;
    st_d.irq      = 1'b0;
    st_d.count    = st_q.count + COUNT_W'(`WWD_COUNT_ONE);
    if (mode_chg) begin
      // windowed checking only when software asks for it
      st_d.windowed = windowed_mode;                                  // see R1 see R8
      st_d.count    = COUNT_W'(`WWD_COUNT_ZERO);
    end else if (fail) begin
      // response chosen per failure; the counter restarts either way
      st_d.rst_req  = !irq_response_select;                           // see R3 see R7 see R9
      st_d.irq      = irq_response_select;                            // see R3 see R7 see R9
      st_d.count    = COUNT_W'(`WWD_COUNT_ZERO);
    end else if (svc == wwd_pkg::WWD_SVC_OK) begin
      st_d.count    = COUNT_W'(`WWD_COUNT_ZERO);                       // see R10
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // reset leaves it running single-threshold, nothing to switch on
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q.count    <= COUNT_W'(`WWD_COUNT_ZERO);                      // see R4
      st_q.windowed <= `WWD_RST_MODE;                                 // see R4 see R8
      st_q.rst_req  <= 1'b0;
      st_q.irq      <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign warm_rst_req    = st_q.rst_req;
  assign cpu_irq         = st_q.irq;
  assign windowed_active = st_q.windowed;
  assign wd_count        = st_q.count;

  // ****************************************
  // assertions
  // ****************************************
  property p_r1_one_limit;
    @(posedge clock) disable iff (sys_rst)
    (st_q.windowed && !mode_chg && !service_key_wr && st_q.count < window_upper)
      |=> !warm_rst_req && !cpu_irq;
  endproperty
  a_r1_one_limit: assert property (p_r1_one_limit) // see R1
    else $error("windowed mode failed below its upper bound");

  property p_r2_expiry;
    @(posedge clock) disable iff (sys_rst)
    (!st_q.windowed && !mode_chg && !service_key_wr && st_q.count >= timeout_limit)
      |=> (warm_rst_req || cpu_irq) && wd_count == COUNT_W'(`WWD_COUNT_ZERO);
  endproperty
  a_r2_expiry: assert property (p_r2_expiry) // see R2
    else $error("single-threshold expiry gave no response");

  property p_r3_reset_resp;
    @(posedge clock) disable iff (sys_rst)
    // a pulse lasts one cycle unless a new failure follows at once
    (fail && !st_q.windowed && !irq_response_select)
      |=> warm_rst_req && !cpu_irq ##1 (!warm_rst_req || $past(fail));
  endproperty
  a_r3_reset_resp: assert property (p_r3_reset_resp) // see R3
    else $error("single-threshold failure did not pulse the warm reset request");

  property p_r4_after_reset;
    @(posedge clock)
    $fell(sys_rst) |-> !windowed_active && wd_count == COUNT_W'(`WWD_COUNT_ZERO)
      ##1 wd_count != COUNT_W'(`WWD_COUNT_ZERO) || warm_rst_req || cpu_irq || windowed_mode;
  endproperty
  a_r4_after_reset: assert property (p_r4_after_reset) // see R4
    else $error("watchdog not running single-threshold after reset");

  property p_r5_early;
    @(posedge clock) disable iff (sys_rst)
    (st_q.windowed && !mode_chg && service_key_wr && service_key == KEY_VAL
      && st_q.count < window_lower) |=> warm_rst_req || cpu_irq;
  endproperty
  a_r5_early: assert property (p_r5_early) // see R5
    else $error("early key in windowed mode was accepted");

  property p_r6_bad_key;
    @(posedge clock) disable iff (sys_rst)
    (st_q.windowed && !mode_chg && service_key_wr && service_key != KEY_VAL)
      |=> warm_rst_req || cpu_irq;
  endproperty
  a_r6_bad_key: assert property (p_r6_bad_key) // see R6
    else $error("wrong key in windowed mode was not flagged");

  property p_r7_irq_resp;
    @(posedge clock) disable iff (sys_rst)
    (fail && st_q.windowed && irq_response_select)
      |=> cpu_irq && !warm_rst_req ##1 (!cpu_irq || $past(fail));
  endproperty
  a_r7_irq_resp: assert property (p_r7_irq_resp) // see R7
    else $error("windowed failure did not pulse the interrupt");

  property p_r9_select;
    @(posedge clock) disable iff (sys_rst)
    (warm_rst_req || cpu_irq) |-> (cpu_irq == $past(irq_response_select)) && !(cpu_irq && warm_rst_req);
  endproperty
  a_r9_select: assert property (p_r9_select) // see R9
    else $error("response does not follow the select bit");

  property p_r10_restart;
    @(posedge clock) disable iff (sys_rst)
    (svc == wwd_pkg::WWD_SVC_OK && !mode_chg)
      |=> wd_count == COUNT_W'(`WWD_COUNT_ZERO) && !warm_rst_req && !cpu_irq;
  endproperty
  a_r10_restart: assert property (p_r10_restart) // see R10
    else $error("good service did not restart the counter");

  // a switch takes effect at the next edge and never counts as a failure
  property p_r1_mode_switch;
    @(posedge clock) disable iff (sys_rst)
    mode_chg |=> windowed_active == $past(windowed_mode)
      && wd_count == COUNT_W'(`WWD_COUNT_ZERO) && !warm_rst_req && !cpu_irq;
  endproperty
  a_r1_mode_switch: assert property (p_r1_mode_switch) // see R1
    else $error("mode switch did not restart cleanly");

  property p_r2_bad_key;
    @(posedge clock) disable iff (sys_rst)
    (!st_q.windowed && !mode_chg && service_key_wr && service_key != KEY_VAL)
      |=> (warm_rst_req || cpu_irq) && wd_count == COUNT_W'(`WWD_COUNT_ZERO);
  endproperty
  a_r2_bad_key: assert property (p_r2_bad_key) // see R2
    else $error("wrong key in single-threshold mode was not flagged");

  property p_r3_irq_resp;
    @(posedge clock) disable iff (sys_rst)
    (fail && !st_q.windowed && irq_response_select) |=> cpu_irq && !warm_rst_req;
  endproperty
  a_r3_irq_resp: assert property (p_r3_irq_resp) // see R3
    else $error("single-threshold failure did not raise the interrupt");

  property p_r7_reset_resp;
    @(posedge clock) disable iff (sys_rst)
    (fail && st_q.windowed && !irq_response_select) |=> warm_rst_req && !cpu_irq;
  endproperty
  a_r7_reset_resp: assert property (p_r7_reset_resp) // see R7
    else $error("windowed failure did not raise the warm reset request");

  // cover points for the main scenarios
  c_mode_switch: cover property (@(posedge clock) disable iff (sys_rst)
    mode_chg ##1 windowed_active);
  c_window_service: cover property (@(posedge clock) disable iff (sys_rst)
    st_q.windowed && svc == wwd_pkg::WWD_SVC_OK);
  c_timeout_reset: cover property (@(posedge clock) disable iff (sys_rst)
    !st_q.windowed && expired ##1 warm_rst_req);
  c_bad_key_irq: cover property (@(posedge clock) disable iff (sys_rst)
    svc == wwd_pkg::WWD_SVC_BAD ##1 cpu_irq);

endmodule
`default_nettype wire

// *** wwd_defs.svh ***
// constants shared by the windowed watchdog design
// Behaviour
// R1: the watchdog runs either single-threshold or windowed, never both at once.
// R2: in single-threshold mode a correct key must arrive before the timeout; expiry or a wrong key is a failure.
// R3: a single-threshold failure gives a warm reset request or a CPU interrupt as configured.
// R4: after reset the watchdog runs at once in single-threshold mode with no software action.
// R5: windowed mode holds lower and upper bounds and only a key between them services the watchdog.
// R6: windowed mode fails on a missing, early or wrong key.
// R7: a windowed failure gives a warm reset request or a CPU interrupt as configured.
// R8: software must select windowed mode itself; windowed checking is off out of reset.
// R9: a configuration bit selects the interrupt response instead of the reset response.
// R10: a correct key inside the allowed time restarts the counter from zero for a new period.
`ifndef WWD_DEFS_SVH
`define WWD_DEFS_SVH

// ****************************************
// widths and values
// ****************************************
`define WWD_COUNT_W    16
`define WWD_KEY_W      8
`define WWD_KEY_VAL    8'ha5
`define WWD_COUNT_ZERO 16'h0000
`define WWD_COUNT_ONE  16'h0001
`define WWD_RST_MODE   1'b0

`endif

// *** wwd_pkg.sv ***
// types for the windowed watchdog
`default_nettype none
package wwd_pkg;
  // outcome of one key write
  typedef enum logic [1:0] {
    WWD_SVC_NONE,
    WWD_SVC_OK,
    WWD_SVC_BAD
  } wwd_svc_t;
endpackage
`default_nettype wire

// *** wwd_key_check.sv ***
// classifies a key write against the key value and the open service window
`include "wwd_defs.svh"
`default_nettype none
module wwd_key_check #(
  parameter int                 COUNT_W = `WWD_COUNT_W,
  parameter int                 KEY_W   = `WWD_KEY_W,
  parameter logic [KEY_W-1:0]   KEY_VAL = `WWD_KEY_VAL
) (
  input  wire logic [KEY_W-1:0]   key,
  input  wire logic               key_wr,
  input  wire logic               windowed,
  input  wire logic [COUNT_W-1:0] count,
  input  wire logic [COUNT_W-1:0] lower,
  input  wire logic [COUNT_W-1:0] limit,
  output wwd_pkg::wwd_svc_t       svc
);

  // ****************************************
  // window and key decision
  // ****************************************
  logic too_early;
  logic too_late;

  // lower bound only counts in windowed mode
  assign too_early = windowed && (count < lower);          // see R5
  assign too_late  = count > limit;

  always_comb begin
    svc = wwd_pkg::WWD_SVC_NONE;
    if (key_wr) begin
      if (key != KEY_VAL || too_early || too_late) begin    // see R2 see R6
        svc = wwd_pkg::WWD_SVC_BAD;
      end else begin
        svc = wwd_pkg::WWD_SVC_OK;
      end
    end
  end

endmodule
`default_nettype wire

// *** windowed_watchdog_tb_top.sv ***
// self-checking testbench for the windowed watchdog top level
`default_nettype none
module windowed_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        clock;
  logic        sys_rst;
  logic        service_key_wr;
  logic [7:0]  service_key;
  logic        windowed_mode;
  logic        irq_response_select;
  logic [15:0] timeout_limit;
  logic [15:0] window_lower;
  logic [15:0] window_upper;
  logic        warm_rst_req;
  logic        cpu_irq;
  logic        windowed_active;
  logic [15:0] wd_count;
  logic [15:0] seen_count;
  int          num_errors;
  int          checked;

  wwd_top dut (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .service_key_wr      (service_key_wr),
    .service_key         (service_key),
    .windowed_mode       (windowed_mode),
    .irq_response_select (irq_response_select),
    .timeout_limit       (timeout_limit),
    .window_lower        (window_lower),
    .window_upper        (window_upper),
    .warm_rst_req        (warm_rst_req),
    .cpu_irq             (cpu_irq),
    .windowed_active     (windowed_active),
    .wd_count            (wd_count)
  );

  // free running clock, 4 ns period
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic results;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // both response pulses and the counter, sampled after the edge has landed
  task automatic outcome(input logic w, input logic i);
    check({14'h0000, warm_rst_req, cpu_irq}, {14'h0000, w, i});
    check(wd_count, 16'h0000);
  endtask

  // bounded wait; a stuck counter ends the run rather than hanging it
  // the first look waits 1 ns so the counter never races its own edge
  task automatic wait_count(input logic [15:0] t);
    #1;
    for (int n = 0; n < 200 && wd_count !== t; n++) begin
      @(posedge clock);
      #1;
    end
    if (wd_count !== t) begin
      check(wd_count, t);
      results();
    end
  endtask

  // one-cycle key strobe; the count of the strobe cycle is what gets judged
  task automatic key_case(input logic [7:0] k, input logic [15:0] c, input logic w,
                          input logic i);
    @(posedge clock);
    service_key_wr <= 1'b1;
    service_key    <= k;
    #1 seen_count = wd_count;
    @(posedge clock);
    service_key_wr <= 1'b0;
    #1;
    check(seen_count, c);
    outcome(w, i);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    timeout_limit <= 16'h0003;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    #1;
    check({15'h0000, windowed_active}, 16'h0000);
    wait_count(16'h0003);
    @(posedge clock);
    #1 outcome(1'b1, 1'b0);
    wait_count(16'h0003);
    @(posedge clock);
    #1 outcome(1'b1, 1'b0);
    $display("reset test done");
  endtask

  task automatic t_service;
    @(posedge clock);
    timeout_limit <= 16'h0014;
    wait_count(16'h0002);
    key_case(8'ha5, 16'h0003, 1'b0, 1'b0);
    key_case(8'ha5, 16'h0001, 1'b0, 1'b0);
    wait_count(16'h0013);
    key_case(8'ha5, 16'h0014, 1'b0, 1'b0);
    key_case(8'h5a, 16'h0001, 1'b1, 1'b0);
    $display("service test done");
  endtask

  task automatic t_irq;
    @(posedge clock);
    irq_response_select <= 1'b1;
    timeout_limit       <= 16'h0003;
    wait_count(16'h0003);
    @(posedge clock);
    #1 outcome(1'b0, 1'b1);
    key_case(8'h00, 16'h0001, 1'b0, 1'b1);
    $display("irq test done");
  endtask

  // single limit stays at 3, so a count past 3 proves only the window applies
  task automatic t_window;
    @(posedge clock);
    irq_response_select <= 1'b0;
    window_lower        <= 16'h0004;
    window_upper        <= 16'h0008;
    windowed_mode       <= 1'b1;
    @(posedge clock);
    #1;
    check({15'h0000, windowed_active}, 16'h0001);
    outcome(1'b0, 1'b0);
    key_case(8'ha5, 16'h0001, 1'b1, 1'b0);
    wait_count(16'h0002);
    key_case(8'ha5, 16'h0003, 1'b1, 1'b0);
    wait_count(16'h0003);
    key_case(8'ha5, 16'h0004, 1'b0, 1'b0);
    wait_count(16'h0007);
    key_case(8'ha5, 16'h0008, 1'b0, 1'b0);
    wait_count(16'h0008);
    @(posedge clock);
    #1 outcome(1'b1, 1'b0);
    @(posedge clock);
    irq_response_select <= 1'b1;
    key_case(8'h3c, 16'h0002, 1'b0, 1'b1);
    // a wrong key in the switching cycle is ignored, so no pulse follows
    @(posedge clock);
    windowed_mode  <= 1'b0;
    service_key_wr <= 1'b1;
    service_key    <= 8'h3c;
    @(posedge clock);
    service_key_wr <= 1'b0;
    #1;
    check({15'h0000, windowed_active}, 16'h0000);
    outcome(1'b0, 1'b0);
    $display("window test done");
  endtask

  // main sequence, with every input defined from time zero
  initial begin
    num_errors          = 0;
    checked             = 0;
    sys_rst             = 1'b1;
    service_key_wr      = 1'b0;
    service_key         = 8'h00;
    windowed_mode       = 1'b0;
    irq_response_select = 1'b0;
    timeout_limit       = 16'h0003;
    window_lower        = 16'h0000;
    window_upper        = 16'h0000;
    t_reset();
    t_service();
    t_irq();
    t_window();
    results();
  end
endmodule
`default_nettype wire
